// ### rtl/tcd_map.svh
// register offsets, field positions, reset values and timing for the terminal command decoder
`ifndef TCD_MAP_SVH
`define TCD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets and preset window select
// ----------------------------------------------------------------
`define TCD_REG_MODE    8'h00
`define TCD_REG_FILT    8'h04
`define TCD_REG_MAXF    8'h08
`define TCD_REG_SRC     8'h0c
`define TCD_REG_STAT    8'h10
`define TCD_REG_OUT     8'h14
`define TCD_REG_FUNC    8'h18
`define TCD_PRESET_SEL  2'h1

// ----------------------------------------------------------------
// reset values and filter time limit
// ----------------------------------------------------------------
`define TCD_MODE_RST    2'h0
`define TCD_FILT_RST    10'h00a
`define TCD_FILT_MAX    10'h3e8
`define TCD_MAXF_RST    16'h1388
`define TCD_SRC_RST     2'h0
`define TCD_PRESET_RST  16'h0000

// ----------------------------------------------------------------
// scaling, function codes and timing
// ----------------------------------------------------------------
`define TCD_PCT_FULL    32'd1000
`define TCD_FC_NONE     4'h0
`define TCD_FC_ONE      4'h1
`define TCD_FC_TWO      4'h2
`define TCD_FC_THREE    4'h3
`define TCD_MS_NS       1000000
`define TCD_CLK_NS      20

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define TCD_ST_RUN      16
`define TCD_ST_AHEAD    17
`define TCD_ST_BACK     18
`define TCD_ST_IDX      20
`define TCD_ST_RAMP     24
`define TCD_ST_MOTOR    26
`define TCD_ST_MODE     28

`endif

// ### rtl/tcd_pkg.sv
// types shared by the terminal command decoder
package tcd_pkg;

    typedef enum logic [1:0] {
        TCD_TWO_ONE   = 2'h0,
        TCD_TWO_TWO   = 2'h1,
        TCD_THREE_ONE = 2'h2,
        TCD_THREE_TWO = 2'h3
    } tcd_mode_e;

    typedef enum logic [2:0] {
        TCD_ST_STOP  = 3'b001,
        TCD_ST_AHEAD = 3'b010,
        TCD_ST_BACK  = 3'b100
    } tcd_run_e;

    typedef enum logic [1:0] {
        TCD_SRC_FREQ = 2'h0,
        TCD_SRC_PID  = 2'h1,
        TCD_SRC_VF   = 2'h2
    } tcd_src_e;

endpackage

// ### rtl/tcd_filter.sv
// synchroniser and debounce filter for the digital input terminals
`timescale 1ns/1ps
`default_nettype none

module tcd_filter #(
    parameter int WIDTH       = 12,
    parameter int TICK_CYCLES = 50000
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             srst,
    // filter time in milliseconds
    input  wire logic [9:0]       filt_ms,
    // raw pins and filtered levels
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] sync1_ff;
    logic [WIDTH-1:0] sync2_ff;
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] level_ff;
    logic [16:0]      tick_cnt_ff;
    logic             tick;
    logic [9:0]       cnt_ff [WIDTH];

    // ----------------------------------------------------------------
    // two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // ----------------------------------------------------------------
    // millisecond tick; free running, so first step may be short
    // ----------------------------------------------------------------
    assign tick = (tick_cnt_ff == 17'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (srst || tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 17'h00001;
        end
    end

    // ----------------------------------------------------------------
    // per-terminal stability timer
    // ----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                cnt_ff[i]   <= '0;
                level_ff[i] <= 1'b0;
            end else if (sync2_ff[i] != prev_ff[i]) begin
                cnt_ff[i] <= '0;
            end else if (sync2_ff[i] == level_ff[i]) begin
                cnt_ff[i] <= '0;
            end else if (cnt_ff[i] >= filt_ms) begin
                level_ff[i] <= sync2_ff[i];
                cnt_ff[i]   <= '0;
            end else if (tick) begin
                cnt_ff[i] <= cnt_ff[i] + 10'h001;
            end
        end
    end

    assign level_out = level_ff;

endmodule // tcd_filter

`default_nettype wire

// ### rtl/tcd_top.sv
// terminal command decoder: preset, ramp and motor selection, run commands, apb registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.svh"

module tcd_top
    import tcd_pkg::*;
#(
    parameter int          CLK_PERIOD_NS = `TCD_CLK_NS,
    parameter int          MS_CYCLES     = `TCD_MS_NS / CLK_PERIOD_NS,
    parameter logic [15:0] MAXF_DEFAULT  = `TCD_MAXF_RST
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // terminal pins
    input  wire logic        digital_input_one,
    input  wire logic        digital_input_two,
    input  wire logic        digital_input_three,
    input  wire logic        switch_one,
    input  wire logic        switch_two,
    input  wire logic        switch_three,
    input  wire logic        switch_four,
    input  wire logic        ramp_term_one,
    input  wire logic        ramp_term_two,
    input  wire logic        motor_term_one,
    input  wire logic        motor_term_two,
    input  wire logic        mode_switch_term,
    // run command
    output logic             forward_run,
    output logic             reverse_run,
    // selections
    output logic      [3:0]  preset_index,
    output logic      [1:0]  ramp_select,
    output logic      [1:0]  motor_select,
    // reference outputs
    output logic      [15:0] freq_reference,
    output logic      [15:0] pid_setpoint,
    output logic      [15:0] vf_voltage_ref
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [1:0]  mode_cfg_ff;
    logic [9:0]  filt_ms_ff;
    logic [15:0] maxf_ff;
    logic [1:0]  src_ff;
    logic [15:0] preset_ff [16];
    logic [31:0] prdata_ff;
    logic        err_ff;
    logic [11:0] raw_vec;
    logic [11:0] lvl;
    logic [11:0] lvl_prev_ff;
    logic        in_one;
    logic        in_two;
    logic        in_three;
    logic        rise_one;
    logic        rise_two;
    tcd_mode_e   mode_eff;
    tcd_mode_e   mode_prev_ff;
    tcd_run_e    run_ff;
    tcd_run_e    nxt_run;
    logic        nxt_ahead;
    logic        nxt_back;
    logic        ahead_ff;
    logic        back_ff;
    logic [3:0]  idx_ff;
    logic [1:0]  ramp_ff;
    logic [1:0]  motor_ff;
    logic [15:0] freq_ff;
    logic [15:0] pid_ff;
    logic [15:0] vf_ff;
    logic        wr_en;
    logic        setup;
    logic        is_preset;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] scale_pct(input logic [15:0] pct, input logic [15:0] full);
        logic [31:0] prod;
        prod = 32'(pct) * 32'(full);
        return 16'(prod / `TCD_PCT_FULL);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[7:6] == `TCD_PRESET_SEL) || (a == `TCD_REG_MODE) || (a == `TCD_REG_FILT)
            || (a == `TCD_REG_MAXF) || (a == `TCD_REG_SRC) || (a == `TCD_REG_STAT)
            || (a == `TCD_REG_OUT) || (a == `TCD_REG_FUNC);
    endfunction

    // ----------------------------------------------------------------
    // input filter
    // ----------------------------------------------------------------
    assign raw_vec = {mode_switch_term, motor_term_two, motor_term_one, ramp_term_two, ramp_term_one,
                      switch_four, switch_three, switch_two, switch_one,
                      digital_input_three, digital_input_two, digital_input_one};

    tcd_filter #(
        .WIDTH       (12),
        .TICK_CYCLES (MS_CYCLES)
    ) u_filter (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .filt_ms   (filt_ms_ff),
        .raw_in    (raw_vec),
        .level_out (lvl)
    );

    assign in_one   = lvl[0];
    assign in_two   = lvl[1];
    assign in_three = lvl[2];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lvl_prev_ff <= '0;
        end else begin
            lvl_prev_ff <= lvl;
        end
    end

    // edges, not levels, so a held button acts once
    assign rise_one = in_one & ~lvl_prev_ff[0];
    assign rise_two = in_two & ~lvl_prev_ff[1];

    // ----------------------------------------------------------------
    // apb slave: zero wait states, read data caught in setup
    // ----------------------------------------------------------------
    assign setup     = psel & ~penable;
    assign wr_en     = psel & penable & pwrite & mapped(paddr);
    assign is_preset = (paddr[7:6] == `TCD_PRESET_SEL);
    assign pready    = 1'b1;
    assign prdata    = prdata_ff;
    assign pslverr   = psel & penable & err_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata_ff <= '0;
            err_ff    <= 1'b0;
        end else if (setup) begin
            err_ff    <= ~mapped(paddr);
            prdata_ff <= '0;
            if (is_preset) begin
                prdata_ff <= {16'h0000, preset_ff[paddr[5:2]]};
            end else begin
                case (paddr)
                    `TCD_REG_MODE: prdata_ff <= {30'h0, mode_cfg_ff};
                    `TCD_REG_FILT: prdata_ff <= {22'h0, filt_ms_ff};
                    `TCD_REG_MAXF: prdata_ff <= {16'h0000, maxf_ff};
                    `TCD_REG_SRC:  prdata_ff <= {30'h0, src_ff};
                    `TCD_REG_STAT: begin
                        prdata_ff[11:0]                       <= lvl;
                        prdata_ff[`TCD_ST_RUN]                <= ahead_ff | back_ff;
                        prdata_ff[`TCD_ST_AHEAD]              <= ahead_ff;
                        prdata_ff[`TCD_ST_BACK]               <= back_ff;
                        prdata_ff[`TCD_ST_IDX+3:`TCD_ST_IDX]     <= idx_ff;
                        prdata_ff[`TCD_ST_RAMP+1:`TCD_ST_RAMP]   <= ramp_ff;
                        prdata_ff[`TCD_ST_MOTOR+1:`TCD_ST_MOTOR] <= motor_ff;
                        prdata_ff[`TCD_ST_MODE+1:`TCD_ST_MODE]   <= mode_eff;
                    end
                    `TCD_REG_OUT:  prdata_ff <= {16'h0000, preset_ff[idx_ff]};
                    `TCD_REG_FUNC: begin
                        prdata_ff[3:0] <= `TCD_FC_ONE;
                        prdata_ff[7:4] <= `TCD_FC_TWO;
                        prdata_ff[11:8] <= mode_eff[1] ? `TCD_FC_THREE : `TCD_FC_NONE;
                    end
                    default:       prdata_ff <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_cfg_ff <= `TCD_MODE_RST;
            filt_ms_ff  <= `TCD_FILT_RST;
            maxf_ff     <= MAXF_DEFAULT;
            src_ff      <= `TCD_SRC_RST;
        end else if (wr_en && !is_preset) begin
            case (paddr)
                `TCD_REG_MODE: mode_cfg_ff <= pwdata[1:0];
                // clamp keeps the timer within one second
                `TCD_REG_FILT: filt_ms_ff <= (pwdata[31:0] > 32'(`TCD_FILT_MAX)) ?
                                             `TCD_FILT_MAX : pwdata[9:0];
                `TCD_REG_MAXF: maxf_ff <= pwdata[15:0];
                `TCD_REG_SRC:  src_ff <= (pwdata[1:0] == 2'h3) ? src_ff : pwdata[1:0];
                default:       mode_cfg_ff <= mode_cfg_ff;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 16; i++) begin
                preset_ff[i] <= `TCD_PRESET_RST;
            end
        end else if (wr_en && is_preset) begin
            preset_ff[paddr[5:2]] <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // selection decode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            idx_ff   <= '0;
            ramp_ff  <= '0;
            motor_ff <= '0;
        end else begin
            idx_ff   <= {lvl[6], lvl[5], lvl[4], lvl[3]};
            ramp_ff  <= {lvl[8], lvl[7]};
            motor_ff <= {lvl[10], lvl[9]};
        end
    end

    assign preset_index = idx_ff;
    assign ramp_select  = ramp_ff;
    assign motor_select = motor_ff;

    // ----------------------------------------------------------------
    // preset routing; unused destinations read zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_ff <= '0;
            pid_ff  <= '0;
            vf_ff   <= '0;
        end else begin
            freq_ff <= (src_ff == TCD_SRC_FREQ) ? scale_pct(preset_ff[idx_ff], maxf_ff) : 16'h0000;
            pid_ff  <= (src_ff == TCD_SRC_PID) ? preset_ff[idx_ff] : 16'h0000;
            vf_ff   <= (src_ff == TCD_SRC_VF) ? preset_ff[idx_ff] : 16'h0000;
        end
    end

    assign freq_reference = freq_ff;
    assign pid_setpoint   = pid_ff;
    assign vf_voltage_ref = vf_ff;

    // ----------------------------------------------------------------
    // command mode
    // ----------------------------------------------------------------
    always_comb begin
        mode_eff = tcd_mode_e'(mode_cfg_ff);
        if (mode_cfg_ff == TCD_TWO_ONE && lvl[11]) begin
            mode_eff = TCD_THREE_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_prev_ff <= TCD_TWO_ONE;
        end else begin
            mode_prev_ff <= mode_eff;
        end
    end

    // ----------------------------------------------------------------
    // latched run state for three-line modes
    // ----------------------------------------------------------------
    always_comb begin
        nxt_run = run_ff;
        if (!mode_eff[1] || mode_eff != mode_prev_ff || !in_three) begin
            nxt_run = TCD_ST_STOP;
        end else begin
            case (mode_eff)
                TCD_THREE_ONE: begin
                    // simultaneous presses leave the state alone
                    if (rise_one && !rise_two) begin
                        nxt_run = TCD_ST_AHEAD;
                    end else if (rise_two && !rise_one) begin
                        nxt_run = TCD_ST_BACK;
                    end
                end
                TCD_THREE_TWO: begin
                    if (rise_one) begin
                        nxt_run = TCD_ST_AHEAD;
                    end
                end
                default: nxt_run = TCD_ST_STOP;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            run_ff <= TCD_ST_STOP;
        end else begin
            run_ff <= nxt_run;
        end
    end

    // ----------------------------------------------------------------
    // run command outputs
    // ----------------------------------------------------------------
    always_comb begin
        nxt_ahead = 1'b0;
        nxt_back  = 1'b0;
        case (mode_eff)
            TCD_TWO_ONE: begin
                nxt_ahead = in_one & ~in_two;
                nxt_back  = in_two & ~in_one;
            end
            TCD_TWO_TWO: begin
                nxt_ahead = in_one & ~in_two;
                nxt_back  = in_one & in_two;
            end
            TCD_THREE_ONE: begin
                nxt_ahead = (nxt_run == TCD_ST_AHEAD);
                nxt_back  = (nxt_run == TCD_ST_BACK);
            end
            TCD_THREE_TWO: begin
                // direction follows the live level while running
                nxt_ahead = (nxt_run == TCD_ST_AHEAD) & ~in_two;
                nxt_back  = (nxt_run == TCD_ST_AHEAD) & in_two;
            end
            default: begin
                nxt_ahead = 1'b0;
                nxt_back  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ahead_ff <= 1'b0;
            back_ff  <= 1'b0;
        end else begin
            ahead_ff <= nxt_ahead;
            back_ff  <= nxt_back;
        end
    end

    assign forward_run = ahead_ff;
    assign reverse_run = back_ff;

endmodule // tcd_top

`default_nettype wire

// ### verif/tcd_checker.sv
// concurrent checks on the terminal command decoder ports
`timescale 1ns/1ps
`default_nettype none

module tcd_checker (
    // clock, reset and apb
    input wire logic        clk_sys, srst, psel, penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready, pslverr,
    // terminals
    input wire logic        digital_input_two, switch_one, switch_two, switch_three, switch_four,
    input wire logic        ramp_term_one, ramp_term_two, motor_term_one, motor_term_two,
    // outputs
    input wire logic        forward_run, reverse_run,
    input wire logic [3:0]  preset_index,
    input wire logic [1:0]  ramp_select, motor_select
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // a new selection must match pins seen three edges back; a longer filter only widens that margin
    chk_ready_nowait: assert property (psel && !penable |=> pready)
        else $error("pready low in access phase");
    chk_unmapped_err: assert property (psel && penable && paddr == 8'h1c |-> pslverr)
        else $error("no error on unmapped address");
    chk_preset_pins: assert property ($changed(preset_index) |->
        preset_index == {$past(switch_four, 3), $past(switch_three, 3), $past(switch_two, 3), $past(switch_one, 3)})
        else $error("preset index not from pins");
    chk_ramp_pins: assert property ($changed(ramp_select) |->
        ramp_select == {$past(ramp_term_two, 3), $past(ramp_term_one, 3)})
        else $error("ramp select not from pins");
    chk_motor_pins: assert property ($changed(motor_select) |->
        motor_select == {$past(motor_term_two, 3), $past(motor_term_one, 3)})
        else $error("motor select not from pins");
    chk_run_onehot: assert property (!(forward_run && reverse_run))
        else $error("forward and reverse together");
    chk_rev_needs_two: assert property ($rose(reverse_run) |-> $past(digital_input_two, 3))
        else $error("reverse without input two");
    chk_reset_quiet: assert property ($fell(srst) |-> !forward_run && !reverse_run && preset_index == 4'h0)
        else $error("outputs not cleared by reset");
endmodule // tcd_checker

`default_nettype wire

// ### verif/tcd_switches.sv
// switches and pushbuttons on the terminal pins, with contact bounce on change
`timescale 1ns/1ps
`default_nettype none

module tcd_switches (
    input  wire logic        clk_sys,
    input  wire logic [11:0] want,
    input  wire logic [3:0]  bounce,
    output logic      [11:0] pins = 12'h000
);
    logic [11:0] tgt_ff = 12'h000;
    logic [11:0] old_ff = 12'h000;
    logic [3:0]  cnt_ff = 4'h0;

    // a changed contact chatters between old and new level, so a filter must restart
    always @(posedge clk_sys) begin
        if (want != tgt_ff) begin
            tgt_ff <= want;
            old_ff <= tgt_ff;
            cnt_ff <= bounce;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
        pins <= cnt_ff[0] ? old_ff : tgt_ff;
    end
endmodule // tcd_switches

`default_nettype wire

// ### verif/tcd_top_tb_top.sv
// self-checking bench for the terminal command decoder
`timescale 1ns/1ps
`default_nettype none

module tcd_top_tb_top;
    logic        clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, forward_run, reverse_run;
    logic [3:0]  preset_index, bounce = 4'h0;
    logic [1:0]  ramp_select, motor_select;
    logic [15:0] freq_reference, pid_setpoint, vf_voltage_ref;
    logic [11:0] want = 12'h000, pins;
    logic [2:0]  v, nv;
    int          seed = 32'h0ce8, p[16], maxf, run, lat, eff, m, k, i, cycles = 0, failures = 0, total_checks = 0;

    always #10 clk_sys = ~clk_sys;

    tcd_switches u_sw (.clk_sys(clk_sys), .want(want), .bounce(bounce), .pins(pins));
    tcd_top #(.MS_CYCLES(5)) DUT (.*, .digital_input_one(pins[0]), .digital_input_two(pins[1]),
        .digital_input_three(pins[2]), .switch_one(pins[3]), .switch_two(pins[4]), .switch_three(pins[5]),
        .switch_four(pins[6]), .ramp_term_one(pins[7]), .ramp_term_two(pins[8]), .motor_term_one(pins[9]),
        .motor_term_two(pins[10]), .mode_switch_term(pins[11]));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys); penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, r);
    endtask

    task automatic settle;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict;
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd("mode", 8'h00, 32'h0);
        rd("filt", 8'h04, 32'ha);
        rd("maxf", 8'h08, 32'h1388);
        rd("unmapped", 8'h1c, 32'h0);
        apb(1'b1, 8'h04, 32'h7d0);
        rd("filt clamp", 8'h04, 32'h3e8);
        // two ms filter against twelve cycles of chatter
        apb(1'b1, 8'h04, 32'h2);
        bounce <= 4'hc; want <= 12'h080;
        repeat (21) @(posedge clk_sys);
        chk("ramp early", 32'h0, ramp_select);
        repeat (22) @(posedge clk_sys);
        chk("ramp late", 32'h1, ramp_select);
        apb(1'b1, 8'h04, 32'h0);
        bounce <= 4'h0;
        maxf = $random(seed) & 32'hffff;
        apb(1'b1, 8'h08, maxf);
        for (i = 0; i < 16; i++) begin
            p[i] = (($random(seed)) & 32'h7fffffff) % 1001;
            apb(1'b1, 8'h40 + 8'(4 * i), p[i]);
        end
        for (i = 0; i < 16; i++) begin
            apb(1'b1, 8'h0c, i % 3);
            want <= {1'b0, 2'(i >> 2), 2'(i), 4'(i), 3'b000};
            settle;
            chk("index", i, preset_index);
            chk("ramp", i & 3, ramp_select);
            chk("motor", i >> 2, motor_select);
            chk("freq", (i % 3 == 0) ? p[i] * maxf / 1000 : 0, freq_reference);
            chk("pid", (i % 3 == 1) ? p[i] : 0, pid_setpoint);
            chk("vf", (i % 3 == 2) ? p[i] : 0, vf_voltage_ref);
            rd("out", 8'h14, p[i]);
        end
        // mode four is two-line one with the switch terminal on
        for (m = 0; m < 5; m++) begin
            want <= 12'h000;
            settle;
            apb(1'b1, 8'h00, m % 4);
            if (m < 4) rd("func", 8'h18, (m > 1) ? 32'h321 : 32'h021);
            eff = (m == 4) ? 2 : m;
            run = 0; lat = 0; v = 3'b000;
            want <= {m == 4, 11'h0};
            settle;
            rd("stat", 8'h10, (eff << 28) | ((m == 4) ? 32'h800 : 32'h0));
            for (k = 0; k < 40; k++) begin
                nv = v ^ (3'b001 << ((($random(seed)) & 32'h7fffffff) % 3));
                case (eff)
                    0: run = (nv[0] && !nv[1]) ? 1 : ((!nv[0] && nv[1]) ? 2 : 0);
                    1: run = nv[0] ? (nv[1] ? 2 : 1) : 0;
                    2: if (!nv[2]) run = 0;
                       else if (nv[0] && !v[0]) run = 1;
                       else if (nv[1] && !v[1]) run = 2;
                    default: begin
                        if (!nv[2]) lat = 0;
                        else if (nv[0] && !v[0]) lat = 1;
                        run = lat ? (nv[1] ? 2 : 1) : 0;
                    end
                endcase
                v = nv;
                want <= {m == 4, 8'h00, nv};
                settle;
                chk("forward", run == 1, forward_run);
                chk("reverse", run == 2, reverse_run);
            end
        end
        print_verdict;
    end
endmodule // tcd_top_tb_top

bind tcd_top tcd_checker u_chk (.*);

`default_nettype wire
